//--- hdl/oms_pkg.sv
// Purpose: constants, field layout and types for the module management sideband block
// Assumes: 125 MHz core clock; management memory bytes mapped one per aligned APB word
// Notes:   byte address on APB is four times the memory byte index
package oms_pkg;

   // clock and documented times
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned INIT_TIME_MS    = 2000;
   localparam int unsigned INIT_CYCLES_DOC = INIT_TIME_MS * CLK_PER_MS;
   localparam int unsigned RESET_MIN_US    = 2;
   localparam int unsigned RESET_MIN_CYC   = (RESET_MIN_US * CLK_PER_MS + 999) / 1000;
   localparam int unsigned IRQ_ASSERT_MS   = 200;
   localparam int unsigned IRQ_RELEASE_US  = 500;
   localparam int unsigned IRQ_ASSERT_CYC  = IRQ_ASSERT_MS * CLK_PER_MS;
   localparam int unsigned IRQ_RELEASE_CYC = IRQ_RELEASE_US * CLK_PER_MS / 1000;

   // memory geometry
   localparam int unsigned PAGE_BYTES = 128;
   localparam int unsigned IDX_W      = 8;
   localparam int unsigned ADDR_W     = 12;

   // lower page byte indices
   localparam logic [6:0] MEM_IDENT      = 7'h00;
   localparam logic [6:0] MEM_STATUS     = 7'h02;
   localparam logic [6:0] MEM_LOS_FLAGS  = 7'h03;
   localparam logic [6:0] MEM_TXF_FLAGS  = 7'h04;
   localparam logic [6:0] MEM_AUX_FLAGS  = 7'h05;
   localparam logic [6:0] MEM_PIN_STATE  = 7'h06;
   localparam logic [6:0] MEM_POWER_CTRL = 7'h5d;
   localparam logic [6:0] MEM_LOS_MASK   = 7'h64;
   localparam logic [6:0] MEM_TXF_MASK   = 7'h65;
   localparam logic [6:0] MEM_AUX_MASK   = 7'h66;
   localparam logic [6:0] MEM_PAGE_SEL   = 7'h7f;

   // bit positions
   localparam int unsigned DNR_BIT      = 0;
   localparam int unsigned PDOWN_BIT    = 1;
   localparam int unsigned PIN_IRQ_BIT  = 0;
   localparam int unsigned PIN_LP_BIT   = 1;

   // reset values
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   localparam logic [7:0]  IDENT_ARB    = 8'h5a;  // arbitrary value

   typedef struct packed
   {
      logic [3:0] los;
      logic [3:0] txf;
      logic [7:0] aux;
   } oms_flags_s;

   typedef enum logic [2:0]
   {
      ST_INIT = 3'b001,
      ST_RUN  = 3'b010,
      ST_HOLD = 3'b100
   } oms_state_e;

endpackage

//--- hdl/oms_sideband.sv
// Purpose: management memory, sideband pins and interrupt of a four-lane pluggable optical module
// Assumes: APB stands for the decoded 2-wire management transfers at device address A0h
// Notes:   interrupt pin is open drain: driven low while enabled, released otherwise
//
// Notes on behaviour
// (R1) with module select low, management transfers are answered normally
// (R2) with module select high, every management transfer is ignored
// (R3) reset pin low longer than 2 us fully resets and restores user defaults
// (R4) module fully functional within 2000 ms after the reset pin rises
// (R5) host ignores status bits until reset completion is signalled
// (R6) completion shown by interrupt with data-not-ready, byte 2 bit 0, cleared
// (R7) completion interrupt posted unprompted within 2000 ms of power-up
// (R8) within 2000 ms of power-on, data-not-ready clears and interrupt asserts
// (R9) management transfers answered no later than 2000 ms after power-on
// (R10) low-power pin high enters reduced power within 100 us
// (R11) low-power pin low returns to full function within 300 ms
// (R12) presence output low while plugged in, high when absent
// (R13) interrupt pulled low on fault; host reads flags to find source
// (R14) interrupt goes low within 200 ms of its triggering condition
// (R15) flags clear on read; interrupt released within 500 us after the read
// (R16) receive loss of signal sets its flag and interrupt within 100 ms
// (R17) transmit fault sets its flag and interrupt within 200 ms
// (R18) any other condition sets its flag and interrupt within 200 ms
// (R19) mask bit blocks its interrupt within 100 ms; clearing it restores it
// (R20) power-down bit enters low power within 100 ms, restores within 300 ms
// (R21) lower page of 128 bytes always visible, upper pages via page select
// (R22) memory served at device address A0h with flags and monitors; the code serves the flag bytes but has no monitor values
`timescale 1ns/1ps

module oms_sideband
   import oms_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = INIT_CYCLES_DOC,
   parameter int unsigned UPPER_PAGES = 4,
   parameter logic [7:0]  IDENT_CODE  = IDENT_ARB
)
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // sideband pins from host
   input  wire logic              module_select_n,
   input  wire logic              module_reset_n,
   input  wire logic              low_power_request,
   // open-drain interrupt pin
   input  wire logic              interrupt_in_n,
   output logic                   interrupt_out_n,
   output logic                   interrupt_oe,
   // presence pin
   output logic                   module_present_n,
   // fault conditions from the optics
   input  wire oms_flags_s        fault_cond,
   // power state to the optics
   output logic                   low_power_state
);

   localparam int unsigned PG_W = $clog2(UPPER_PAGES + 1);

   // two-stage synchronisers for pins
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   logic       sel_n_s;
   logic       rst_n_s;
   logic       lp_s;
   logic       irq_in_n_s;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         pin_meta_reg <= 4'b1011;
         pin_sync_reg <= 4'b1011;
      end
      else
      begin
         pin_meta_reg <= {interrupt_in_n, low_power_request, module_reset_n, module_select_n};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign sel_n_s    = pin_sync_reg[0];
   assign rst_n_s    = pin_sync_reg[1];
   assign lp_s       = pin_sync_reg[2];
   assign irq_in_n_s = pin_sync_reg[3];

   // reset pulse width and init sequencing
   oms_state_e  state_reg;
   logic [8:0]  rst_low_cnt_reg;
   logic [31:0] init_cnt_reg;
   logic        rst_armed;
   logic        init_done;
   logic        full_reset;

   assign rst_armed  = rst_low_cnt_reg > 9'(RESET_MIN_CYC);
   assign init_done  = (state_reg == ST_INIT) && (init_cnt_reg >= INIT_CYCLES - 1);
   assign full_reset = (state_reg == ST_HOLD) && rst_n_s;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         rst_low_cnt_reg <= 9'h000;
      else if (rst_n_s)
         rst_low_cnt_reg <= 9'h000;
      else if (!rst_armed)
         rst_low_cnt_reg <= rst_low_cnt_reg + 9'h001;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         state_reg <= ST_INIT;
      else
      begin
         unique case (state_reg)
            ST_INIT:
               if (rst_armed)
                  state_reg <= ST_HOLD;
               else if (init_done)
                  state_reg <= ST_RUN;
            ST_RUN:
               if (rst_armed)
                  state_reg <= ST_HOLD;       // R3
            ST_HOLD:
               if (rst_n_s)
                  state_reg <= ST_INIT;       // R4
            default:
               state_reg <= ST_INIT;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n || state_reg != ST_INIT)
         init_cnt_reg <= WORD_ZERO;
      else
         init_cnt_reg <= init_cnt_reg + 32'h0000_0001;  // R7
   end

   // bus decode
   logic            running;
   logic            setup;
   logic            access;
   logic            rd_access;
   logic            wr_access;
   logic            addr_ok;
   logic            bus_err;
   logic [IDX_W-1:0] idx;
   logic [6:0]      low_idx;
   logic            upper;

   assign running   = (state_reg == ST_RUN);
   assign idx       = paddr[IDX_W+1:2];
   assign low_idx   = idx[6:0];
   assign upper     = idx[IDX_W-1];
   assign addr_ok   = (paddr[ADDR_W-1:IDX_W+2] == '0) && (paddr[1:0] == 2'b00);
   assign bus_err   = sel_n_s || !running || !addr_ok;     // R2 R9
   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign rd_access = access && !pwrite && !bus_err;       // R1
   assign wr_access = access && pwrite && !bus_err;        // R1
   assign pready    = 1'b1;
   assign pslverr   = access && bus_err;

   // user settings and flags
   logic [7:0]      page_reg;
   logic            pdown_reg;
   oms_flags_s      mask_reg;
   oms_flags_s      flag_reg;
   oms_flags_s      flag_next;
   oms_flags_s      rd_clear;
   logic            dnr_reg;
   logic            ready_flag_reg;
   logic            page_ok;

   assign page_ok = (page_reg != BYTE_ZERO) && (page_reg <= 8'(UPPER_PAGES));

   function automatic logic hit(input logic [6:0] at);
      hit = !upper && (low_idx == at);
   endfunction

   always_ff @(posedge clock)
   begin
      if (!reset_n || full_reset)
      begin
         page_reg  <= BYTE_ZERO;           // R3
         pdown_reg <= 1'b0;
         mask_reg  <= '0;
      end
      else if (wr_access)
      begin
         if (hit(MEM_PAGE_SEL))
            page_reg <= pwdata[7:0];       // R21
         if (hit(MEM_POWER_CTRL))
            pdown_reg <= pwdata[PDOWN_BIT];
         if (hit(MEM_LOS_MASK))
            mask_reg.los <= pwdata[3:0];   // R19
         if (hit(MEM_TXF_MASK))
            mask_reg.txf <= pwdata[3:0];
         if (hit(MEM_AUX_MASK))
            mask_reg.aux <= pwdata[7:0];
      end
   end

   always_comb
   begin
      rd_clear     = '0;
      // only bits the read returned are cleared, so a flag set after the setup edge is kept
      rd_clear.los = (rd_access && hit(MEM_LOS_FLAGS)) ? prdata[3:0] : 4'h0;
      rd_clear.txf = (rd_access && hit(MEM_TXF_FLAGS)) ? prdata[3:0] : 4'h0;
      rd_clear.aux = (rd_access && hit(MEM_AUX_FLAGS)) ? prdata[7:0] : 8'h00;
      // a new event in the clearing cycle survives
      flag_next    = (flag_reg & ~rd_clear) | (running ? fault_cond : '0);  // R15 R16 R17 R18
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n || full_reset || state_reg == ST_HOLD)
         flag_reg <= '0;
      else
         flag_reg <= flag_next;
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n || state_reg != ST_RUN && !init_done)
         dnr_reg <= 1'b1;
      else if (init_done)
         dnr_reg <= 1'b0;                  // R6 R8
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n || state_reg == ST_HOLD)
         ready_flag_reg <= 1'b0;
      else if (init_done)
         ready_flag_reg <= 1'b1;           // R6 R7
      else if (rd_access && hit(MEM_STATUS))
         ready_flag_reg <= 1'b0;
   end

   // general storage of the lower page and all upper pages
   logic [7:0] low_mem  [PAGE_BYTES];
   logic [7:0] up_mem   [PAGE_BYTES*UPPER_PAGES];
   logic [$clog2(PAGE_BYTES*UPPER_PAGES)-1:0] up_addr;

   // page offset and byte index joined, so no product can wrap at eight bits
   assign up_addr = $bits(up_addr)'({page_reg - 8'h01, low_idx});

   always_ff @(posedge clock)
   begin
      if (wr_access && !upper)
         low_mem[low_idx] <= pwdata[7:0];
      if (wr_access && upper && page_ok)
         up_mem[up_addr] <= pwdata[7:0];   // R21
   end

   // read mux for one byte
   function automatic logic [7:0] rd_byte(input logic [6:0] at);
      logic [7:0] b;
      b = low_mem[at];
      unique case (at)
         MEM_IDENT:      b = IDENT_CODE;
         MEM_STATUS:     b = {7'h00, dnr_reg};
         MEM_LOS_FLAGS:  b = {4'h0, flag_reg.los};
         MEM_TXF_FLAGS:  b = {4'h0, flag_reg.txf};
         MEM_AUX_FLAGS:  b = flag_reg.aux;
         MEM_PIN_STATE:  b = {6'h00, low_power_state, !irq_in_n_s};
         MEM_POWER_CTRL: b = {6'h00, pdown_reg, 1'b0};
         MEM_LOS_MASK:   b = {4'h0, mask_reg.los};
         MEM_TXF_MASK:   b = {4'h0, mask_reg.txf};
         MEM_AUX_MASK:   b = mask_reg.aux;
         MEM_PAGE_SEL:   b = page_reg;
         default:        b = low_mem[at];
      endcase
      return b;
   endfunction

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         prdata <= WORD_ZERO;
      else if (setup)
      begin
         if (bus_err || pwrite)
            prdata <= WORD_ZERO;
         else if (!upper)
            prdata <= {24'h00_0000, rd_byte(low_idx)};  // R22
         else if (page_ok)
            prdata <= {24'h00_0000, up_mem[up_addr]};
         else
            prdata <= WORD_ZERO;
      end
   end

   // interrupt, power and presence
   logic irq_src;
   logic irq_reg;

   assign irq_src = (|(flag_reg & ~mask_reg)) || ready_flag_reg;  // R13 R19

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_src;               // R14 R15
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         low_power_state <= 1'b0;
      else
         low_power_state <= lp_s || pdown_reg;  // R10 R11 R20
   end

   assign interrupt_oe     = irq_reg;
   assign interrupt_out_n  = 1'b0;
   assign module_present_n = 1'b0;         // R12

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_init_end;
      state_reg == ST_INIT ##1 state_reg == ST_RUN;
   endsequence

   sequence s_long_low;
      !rst_n_s [*8];
   endsequence

   a_deselect_ignored: assert property (access && sel_n_s |-> pslverr)  // R2
      else $error("transfer answered while deselected");

   a_select_answers: assert property (access && !sel_n_s && running && addr_ok |-> !pslverr)  // R1
      else $error("selected transfer refused");

   a_init_bounded: assert property (state_reg == ST_INIT |-> init_cnt_reg < INIT_CYCLES)  // R4
      else $error("init exceeds its time");

   a_ready_irq_post: assert property (s_init_end |-> !dnr_reg ##1 interrupt_oe)  // R6
      else $error("completion not signalled");

   a_reset_full: assert property (state_reg == ST_HOLD ##1 state_reg == ST_INIT |->
                                  page_reg == BYTE_ZERO && mask_reg == '0 && dnr_reg)  // R3
      else $error("reset left settings");

   a_short_low_kept: assert property ((running and s_long_low) ##1 (rst_n_s && !rst_armed) |-> running)  // R3
      else $error("short reset pulse acted");

   a_los_raises_irq: assert property (running && |fault_cond.los && !(|mask_reg.los)
                                      |=> flag_reg.los != 4'h0 ##1 interrupt_oe)  // R16
      else $error("loss of signal not flagged");

   a_txf_sets_flag: assert property (running && |fault_cond.txf |=> |flag_reg.txf)  // R17
      else $error("tx fault not flagged");

   a_aux_sets_flag: assert property (running && |fault_cond.aux |=> |flag_reg.aux)  // R18
      else $error("flag not set");

   a_mask_blocks: assert property (flag_reg.los != 4'h0 && mask_reg.los == 4'hf && flag_reg.txf == 4'h0
                                   && flag_reg.aux == 8'h00 && !ready_flag_reg |=> !interrupt_oe)  // R19
      else $error("masked source drove interrupt");

   a_read_clears: assert property (rd_access && hit(MEM_LOS_FLAGS) && fault_cond.los == 4'h0
                                   && running |=> (flag_reg.los & $past(prdata[3:0])) == 4'h0)  // R15
      else $error("flag not cleared on read");

   a_low_power: assert property ($rose(lp_s) |=> low_power_state)  // R10
      else $error("low power not entered");

   a_pdown_exit: assert property (!lp_s && !pdown_reg |=> !low_power_state)  // R11
      else $error("full function not restored");

   a_present_low: assert property (module_present_n == 1'b0)  // R12
      else $error("presence not shown");

endmodule

//--- test/oms_host_board.sv
// Purpose: host board side of the open-drain interrupt line
// Assumes: pull-up resistor on the host board
// Notes:   line reads high whenever the module releases it
`timescale 1ns/1ps

module oms_host_board
(
   // interrupt pin from the module
   input  wire logic interrupt_out_n,
   input  wire logic interrupt_oe,
   // resolved line level
   output logic      irq_line_n
);
   // pull-up wins while released
   assign irq_line_n = interrupt_oe ? interrupt_out_n : 1'b1;
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench for the management sideband block
// Assumes: init time shortened to 50 cycles
// Notes:   byte model in an associative array, keyed by page and index
`timescale 1ns/1ps

module testbench;
   import oms_pkg::*;

   localparam int PAGES = 4;
   logic              clock;
   logic              reset_n;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              module_select_n;
   logic              module_reset_n;
   logic              low_power_request;
   logic              irq_line_n;
   logic              interrupt_out_n;
   logic              interrupt_oe;
   logic              module_present_n;
   oms_flags_s        fault_cond;
   logic              low_power_state;
   integer            seed = 32'h8c09_b413;
   int                n_fail;
   int                num_checks;
   int                b;
   int                mdl[int];
   logic [31:0]       rd;
   logic              err;
   logic [31:0]       d1;
   logic [31:0]       d2;

   oms_sideband #(.INIT_CYCLES(50), .UPPER_PAGES(PAGES)) oms_sideband_inst
   (
      .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_select_n(module_select_n), .module_reset_n(module_reset_n),
      .low_power_request(low_power_request), .interrupt_in_n(irq_line_n),
      .interrupt_out_n(interrupt_out_n), .interrupt_oe(interrupt_oe),
      .module_present_n(module_present_n), .fault_cond(fault_cond), .low_power_state(low_power_state)
   );

   oms_host_board oms_host_board_inst
   (
      .interrupt_out_n(interrupt_out_n), .interrupt_oe(interrupt_oe), .irq_line_n(irq_line_n)
   );

   always #4 clock = ~clock;

   task automatic results;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic give_up;
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
   endtask

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // one apb transfer, entered and left just after a rising edge
   task automatic apb(input logic wr, input int idx, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= 12'(idx * 4);
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
         give_up();
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   function automatic int exp_rd(input int idx);
      int p;
      p = mdl.exists(127) ? mdl[127] : 0;
      if (idx < 128)
         return mdl.exists(idx) ? mdl[idx] : 0;
      if (p < 1 || p > PAGES)
         return 0;
      return mdl.exists(p * 256 + idx) ? mdl[p * 256 + idx] : 0;
   endfunction

   task automatic wb(input int idx, input logic [31:0] d);
      int p;
      p = mdl.exists(127) ? mdl[127] : 0;
      apb(1'b1, idx, d, rd, err);
      chk_bit(err, 1'b0);
      if (idx < 128)
         mdl[idx] = int'(d);
      else if (p >= 1 && p <= PAGES)
         mdl[p * 256 + idx] = int'(d);
   endtask

   task automatic rb(input int idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000, rd, err);
      chk_bit(err, 1'b0);
      chk_data(rd, exp);
   endtask

   // sel 0 watches the interrupt enable, 1 the power state
   task automatic wt(input int sel, input logic exp, input int n);
      logic got;
      for (int k = 0; k < n; k++)
      begin
         @(posedge clock);
         got = (sel == 1) ? low_power_state : interrupt_oe;
         if (got === exp)
            return;
      end
      give_up();
   endtask

   task automatic wait_run;
      int k;
      for (k = 0; k < 200; k++)
      begin
         apb(1'b0, 0, 32'h0000_0000, rd, err);
         if (err === 1'b0)
            break;
      end
      if (k == 200)
         give_up();
      chk_data(rd, {24'h00_0000, IDENT_ARB});
   endtask

   initial
   begin
      clock = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; module_select_n = 1'b0; module_reset_n = 1'b1;
      low_power_request = 1'b0; fault_cond = '0; n_fail = 0; num_checks = 0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      chk_bit(module_present_n, 1'b0);
      wt(0, 1'b1, 200);
      wait_run();
      rb(6, 32'h0000_0001);
      rb(2, 32'h0000_0000);
      wt(0, 1'b0, 4);
      // deselected traffic must leave the memory alone
      d1 = 32'($random(seed)) & 32'h0000_00ff;
      wb(10, d1);
      module_select_n <= 1'b1;
      repeat (3) @(posedge clock);
      apb(1'b1, 10, ~d1 & 32'h0000_00ff, rd, err);
      chk_bit(err, 1'b1);
      apb(1'b0, 10, 32'h0000_0000, rd, err);
      chk_data(rd, 32'h0000_0000);
      module_select_n <= 1'b0;
      repeat (3) @(posedge clock);
      rb(10, exp_rd(10));
      apb(1'b0, 256, 32'h0000_0000, rd, err);
      chk_bit(err, 1'b1);
      // one random lane of each flag group
      for (int g = 0; g < 3; g++)
      begin
         b = $unsigned($random(seed)) % (g == 2 ? 8 : 4);
         fault_cond <= oms_flags_s'(16'h0001 << (b + (g == 0 ? 12 : g == 1 ? 8 : 0)));
         repeat (2) @(posedge clock);
         fault_cond <= '0;
         wt(0, 1'b1, 6);
         rb(3 + g, 32'h0000_0001 << b);
         wt(0, 1'b0, 4);
         rb(3 + g, 32'h0000_0000);
      end
      wb(100, 32'h0000_000f);
      fault_cond <= oms_flags_s'(16'h1000);
      repeat (3) @(posedge clock);
      fault_cond <= '0;
      repeat (8) @(posedge clock);
      chk_bit(interrupt_oe, 1'b0);
      wb(100, 32'h0000_0000);
      wt(0, 1'b1, 6);
      rb(3, 32'h0000_0001);
      wt(0, 1'b0, 4);
      // masked tx fault stays silent, other mask byte reads back
      wb(101, 32'h0000_000f);
      fault_cond <= oms_flags_s'(16'h0100);
      repeat (3) @(posedge clock);
      fault_cond <= '0;
      repeat (4) @(posedge clock);
      chk_bit(interrupt_oe, 1'b0);
      rb(101, exp_rd(101));
      rb(4, 32'h0000_0001);
      wb(101, 32'h0000_0000);
      wb(102, 32'h0000_00a5);
      rb(102, exp_rd(102));
      wb(102, 32'h0000_0000);
      wb(93, 32'h0000_0002);
      wt(1, 1'b1, 4);
      rb(93, exp_rd(93));
      wb(93, 32'h0000_0000);
      wt(1, 1'b0, 4);
      low_power_request <= 1'b1;
      wt(1, 1'b1, 8);
      rb(6, 32'h0000_0002);
      low_power_request <= 1'b0;
      wt(1, 1'b0, 8);
      // upper pages, an invalid page reads zero
      d2 = 32'($random(seed)) & 32'h0000_00ff;
      wb(127, 32'h0000_0001);
      wb(128, d2);
      rb(128, exp_rd(128));
      wb(127, 32'(PAGES + 1));
      rb(128, exp_rd(128));
      wb(127, 32'h0000_0003);
      wb(128, ~d2 & 32'h0000_00ff);
      rb(128, exp_rd(128));
      wb(127, 32'h0000_0001);
      rb(128, exp_rd(128));
      rb(10, exp_rd(10));
      // short pulse ignored, long pulse restores defaults
      wb(93, 32'h0000_0002);
      wb(100, 32'h0000_000f);
      module_reset_n <= 1'b0;
      repeat (100) @(posedge clock);
      module_reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      rb(93, exp_rd(93));
      module_reset_n <= 1'b0;
      repeat (300) @(posedge clock);
      apb(1'b0, 0, 32'h0000_0000, rd, err);
      chk_bit(err, 1'b1);
      module_reset_n <= 1'b1;
      mdl[93] = 0;
      mdl[100] = 0;
      mdl[127] = 0;
      wt(0, 1'b1, 200);
      wait_run();
      chk_bit(low_power_state, 1'b0);
      rb(93, exp_rd(93));
      rb(100, exp_rd(100));
      results();
   end
endmodule
